// ---- shared/afl_pkg.sv ----
package afl_pkg;

   // Device clock
   localparam int unsigned CLK_HZ = 100_000_000;

   // Times in their own units, nominal figures
   localparam int unsigned FIELD_PWM_HZ       = 250;
   localparam int unsigned START_DELAY_TIME_MS = 5000;
   localparam int unsigned FIELD_RETRY_TIME_MS = 40;
   localparam int unsigned WARNING_QUALIFY_TIME_MS = 400;
   localparam int unsigned RAMP_UP_TIME_MS    = 5000;
   localparam int unsigned RAMP_DN_NUM        = 3;
   localparam int unsigned RAMP_DN_DEN        = 8;

   // Duty is held in tenths of a percent, 0 to 1000
   localparam int unsigned DUTY_FULL = 1000;
   localparam logic [9:0] DUTY_MAX            = 10'h3e8;
   localparam logic [9:0] PRE_EXCITE_DUTY     = 10'h07d;
   localparam logic [9:0] SELF_START_DUTY     = 10'h03c;
   localparam logic [9:0] FIXED_EXCITE_DUTY   = 10'h028;
   localparam logic [9:0] RAMP_TRIGGER_DELTA  = 10'h043;
   localparam logic [9:0] RAMP_START_STEP     = 10'h035;

   // Rotor frequency thresholds in Hz
   localparam logic [11:0] PREEX_EXIT_HZ = 12'h078;
   localparam logic [11:0] PREEX_HYST_HZ = 12'h014;
   localparam logic [11:0] PREEX_ENTER_HZ = PREEX_EXIT_HZ - PREEX_HYST_HZ;
   localparam logic [11:0] RAMP_LIMIT_HZ = 12'h140;

   // Derived cycle counts
   localparam int unsigned PWM_PERIOD_CYC  = CLK_HZ / FIELD_PWM_HZ;
   localparam int unsigned START_DELAY_CYC = (CLK_HZ / 1000) * START_DELAY_TIME_MS;
   localparam int unsigned RETRY_CYC       = (CLK_HZ / 1000) * FIELD_RETRY_TIME_MS;
   localparam int unsigned ALARM_CYC       = (CLK_HZ / 1000) * WARNING_QUALIFY_TIME_MS;
   localparam int unsigned RAMP_UP_STEP_CYC =
      ((CLK_HZ / 1000) * RAMP_UP_TIME_MS) / DUTY_FULL;
   localparam int unsigned RAMP_DN_STEP_CYC =
      ((CLK_HZ / 1000) * RAMP_UP_TIME_MS / DUTY_FULL) * RAMP_DN_NUM / RAMP_DN_DEN;

   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_DEMAND = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_DUTY   = 8'h0c;

   // Control fields and reset value
   localparam int unsigned CTRL_SELF  = 0;
   localparam int unsigned CTRL_FIXED = 1;
   localparam int unsigned CTRL_INT   = 2;
   localparam int unsigned CTRL_RAMP  = 3;
   localparam logic [3:0] CTRL_RESET  = 4'hc;

   // Field operating modes
   typedef enum logic [2:0] {
      MD_PREEX = 3'b000,
      MD_SELF  = 3'b001,
      MD_DELAY = 3'b010,
      MD_FIXED = 3'b011,
      MD_REG   = 3'b100
   } afl_mode_t;

endpackage

// ---- core/afl_qual_timer.sv ----
`timescale 1ns/10ps
// Runs while run_i is high and flags once limit_i cycles have passed.
module afl_qual_timer (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        run_i,
   input  wire logic [31:0] limit_i,
   output logic             done_o
);
   logic [31:0] cnt_r;

   // Restarts from zero whenever run_i drops
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_r  <= 32'h0;
         done_o <= 1'b0;
      end else if (!done_o) begin
         if (cnt_r >= limit_i - 32'h1) begin
            done_o <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 32'h1;
         end
      end
   end

   done_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(done_o) |-> $past(run_i) && $past(cnt_r) == limit_i - 32'h1)
      else $error("Timer finished before its limit");

endmodule

// ---- core/afl_pwm.sv ----
`timescale 1ns/10ps
// Fixed-frequency field PWM; duty sampled only at the period start.
module afl_pwm
   import afl_pkg::*;
#(
   parameter int unsigned PERIOD = 400000
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [9:0] duty_i,
   input  wire logic       kill_i,
   output logic            field_o
);
   localparam int unsigned STEP = PERIOD / DUTY_FULL;

   logic [31:0] cnt_r;
   logic [31:0] on_lim_r;

   // Period counter; a mid-period duty change would give a runt pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r    <= 32'h0;
         on_lim_r <= 32'h0;
      end else begin
         cnt_r <= (cnt_r == PERIOD - 1) ? 32'h0 : cnt_r + 32'h1;
         if (cnt_r == 32'h0) begin
            on_lim_r <= 32'(duty_i) * STEP;
         end
      end
   end

   // Kill cuts the drive at once, not at the next boundary
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         field_o <= 1'b0;
      end else begin
         field_o <= !kill_i && (cnt_r < on_lim_r);
      end
   end

   pwm_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
      on_lim_r != $past(on_lim_r) |-> $past(cnt_r) == 32'h0)
      else $error("PWM duty changed inside a period");

endmodule

// ---- core/afl_field_ctrl.sv ----
`timescale 1ns/10ps
// What this block does
// - Pre-excitation drives the field at 12.5 percent duty.
// - Self-start drives the field at 6 percent duty.
// - Fixed excitation drives the field at 4 percent duty.
// - Internal mode waits 5 s on leaving pre-excitation before normal regulation starts.
// - Over-current turns the field off; retry after 40 ms, repeatedly.
// - The ramp may engage only below the ramp frequency limit.
// - Ramp engages when demand exceeds previous duty by over 6.7 points.
// - Engaging steps duty up by 5.3 points first, then ramps.
// - Ramp up rises full scale in 5 s.
// - Ramp down falls full scale in three eighths of ramp-up time.
// - Lamp turns on only after a fault persists 400 ms.
// - Missing rotor signal, low voltage or low frequency, is a fault.
// - Rotor peak voltage below its floor is a fault.
// - Field over-current is a fault.
// - Battery above internal or external over-voltage limit is a fault.
// - Battery under-voltage is a fault.
// - The ramp acts on the field duty itself.
// - Ramp frequency limit is 320 Hz for entry and exit.
// - Pre-excitation exits above 120 Hz, re-enters below 100 Hz.
module afl_field_ctrl
   import afl_pkg::*;
#(
   parameter int unsigned PWM_PERIOD  = PWM_PERIOD_CYC,
   parameter int unsigned DELAY_CYC   = START_DELAY_CYC,
   parameter int unsigned RETRY_T_CYC = RETRY_CYC,
   parameter int unsigned ALARM_T_CYC = ALARM_CYC,
   parameter int unsigned UP_STEP     = RAMP_UP_STEP_CYC,
   parameter int unsigned DN_STEP     = RAMP_DN_STEP_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [11:0] rotor_speed_input_i,
   input  wire logic        rotor_missing_i,
   input  wire logic        rotor_floor_low_i,
   input  wire logic        excite_overcurrent_i,
   input  wire logic        batt_above_sp_i,
   input  wire logic        field_on_det_i,
   input  wire logic        batt_ovp_int_i,
   input  wire logic        batt_ovp_ext_i,
   input  wire logic        batt_uv_i,
   output logic             field_o,
   output logic             lamp_o
);

   // Register address match, shared by read and write paths
   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
      reg_hit = (adr[7:2] == off[7:2]);
   endfunction

   logic [3:0]  ctrl_r;
   logic [9:0]  demand_r;
   logic [9:0]  dem_eff;
   afl_mode_t   mode_r;
   afl_mode_t   mode_nxt;
   afl_mode_t   run_mode;
   logic        preex_r;
   logic        delay_done;
   logic        ovc_off_r;
   logic        retry_done;
   logic        alarm_done;
   logic [5:0]  fault_vec;
   logic        fault_any;
   logic        lrc_ok;
   logic        ramp_r;
   logic [31:0] tick_r;
   logic [31:0] tick_lim;
   logic [9:0]  cur_r;
   logic [9:0]  mode_duty;
   logic [9:0]  pwm_duty;
   logic        wb_req;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Demand above full scale is treated as full scale
   assign dem_eff = (demand_r > DUTY_MAX) ? DUTY_MAX : demand_r;

   // Register writes land at the edge where the master sees ack; byte lanes honoured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r   <= CTRL_RESET;
         demand_r <= 10'h000;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
         if (reg_hit(wb_adr_i, REG_CTRL) && wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[3:0];
         end
         if (reg_hit(wb_adr_i, REG_DEMAND) && wb_sel_i[0]) begin
            demand_r[7:0] <= wb_dat_i[7:0];
         end
         if (reg_hit(wb_adr_i, REG_DEMAND) && wb_sel_i[1]) begin
            demand_r[9:8] <= wb_dat_i[9:8];
         end
      end
   end

   // Bus answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         if (wb_req && !wb_we_i) begin
            if (reg_hit(wb_adr_i, REG_CTRL)) begin
               wb_dat_o <= {28'h0, ctrl_r};
            end else if (reg_hit(wb_adr_i, REG_DEMAND)) begin
               wb_dat_o <= {22'h0, demand_r};
            end else if (reg_hit(wb_adr_i, REG_STATUS)) begin
               wb_dat_o <= {18'h0, fault_vec, 1'b0, fault_any, lamp_o,
                            ovc_off_r, ramp_r, mode_r};
            end else if (reg_hit(wb_adr_i, REG_DUTY)) begin
               wb_dat_o <= {22'h0, pwm_duty};
            end
         end
      end
   end

   // Pre-excitation with hysteresis so the mode does not chatter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         preex_r <= 1'b1;
      end else if (rotor_speed_input_i > PREEX_EXIT_HZ) begin
         preex_r <= 1'b0;
      end else if (rotor_speed_input_i < PREEX_ENTER_HZ) begin
         preex_r <= 1'b1;
      end
   end

   // Running mode once the rotor turns
   always_comb begin
      if (ctrl_r[CTRL_SELF]) begin
         run_mode = MD_SELF;
      end else if (ctrl_r[CTRL_FIXED]) begin
         run_mode = MD_FIXED;
      end else begin
         run_mode = MD_REG;
      end
   end

   // Mode sequencing; start delay only on internal regulation
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         MD_PREEX: begin
            if (!preex_r) begin
               if (run_mode == MD_REG && ctrl_r[CTRL_INT]) begin
                  mode_nxt = MD_DELAY;
               end else begin
                  mode_nxt = run_mode;
               end
            end
         end
         MD_DELAY: begin
            if (preex_r) begin
               mode_nxt = MD_PREEX;
            end else if (delay_done || run_mode != MD_REG) begin
               mode_nxt = run_mode;
            end
         end
         MD_SELF, MD_FIXED, MD_REG: begin
            mode_nxt = preex_r ? MD_PREEX : run_mode;
         end
         default: begin
            mode_nxt = MD_PREEX;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= MD_PREEX;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   afl_qual_timer u_delay (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (mode_r == MD_DELAY),
      .limit_i (DELAY_CYC),
      .done_o  (delay_done)
   );

   // Fixed duties per mode, regulation takes the ramp duty; the delay holds pre-excitation duty
   always_comb begin
      case (mode_r)
         MD_PREEX: mode_duty = PRE_EXCITE_DUTY;
         MD_DELAY: mode_duty = PRE_EXCITE_DUTY;
         MD_SELF:  mode_duty = SELF_START_DUTY;
         MD_FIXED: mode_duty = FIXED_EXCITE_DUTY;
         default:  mode_duty = cur_r;
      endcase
   end

   assign lrc_ok   = ctrl_r[CTRL_RAMP] && (rotor_speed_input_i < RAMP_LIMIT_HZ);
   assign tick_lim = (dem_eff > cur_r) ? UP_STEP : DN_STEP;

   // Load ramp limiter acting on the regulated duty
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_r  <= 10'h000;
         ramp_r <= 1'b0;
         tick_r <= 32'h0;
      end else if (mode_r != MD_REG) begin
         cur_r  <= mode_duty;
         ramp_r <= 1'b0;
         tick_r <= 32'h0;
      end else if (!lrc_ok) begin
         cur_r  <= dem_eff;
         ramp_r <= 1'b0;
         tick_r <= 32'h0;
      end else if (!ramp_r) begin
         tick_r <= 32'h0;
         if ({1'b0, dem_eff} > {1'b0, cur_r} + {1'b0, RAMP_TRIGGER_DELTA}) begin
            cur_r  <= cur_r + RAMP_START_STEP;
            ramp_r <= 1'b1;
         end else begin
            cur_r <= dem_eff;
         end
      end else if (dem_eff == cur_r) begin
         ramp_r <= 1'b0;
         tick_r <= 32'h0;
      end else if (tick_r >= tick_lim - 32'h1) begin
         tick_r <= 32'h0;
         cur_r  <= (dem_eff > cur_r) ? cur_r + 10'h001 : cur_r - 10'h001;
      end else begin
         tick_r <= tick_r + 32'h1;
      end
   end

   // Over-current latch; the retry timer releases it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovc_off_r <= 1'b0;
      end else if (!ovc_off_r && excite_overcurrent_i) begin
         ovc_off_r <= 1'b1;
      end else if (ovc_off_r && retry_done) begin
         ovc_off_r <= 1'b0;
      end
   end

   afl_qual_timer u_retry (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (ovc_off_r),
      .limit_i (RETRY_T_CYC),
      .done_o  (retry_done)
   );

   assign pwm_duty = ovc_off_r ? 10'h000 : mode_duty;

   afl_pwm #(
      .PERIOD (PWM_PERIOD)
   ) u_pwm (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .duty_i  (pwm_duty),
      .kill_i  (ovc_off_r),
      .field_o (field_o)
   );

   // Fault conditions that qualify the warning lamp
   assign fault_vec[0] = rotor_missing_i || (rotor_speed_input_i < PREEX_ENTER_HZ);
   assign fault_vec[1] = rotor_floor_low_i;
   // The trip latch counts too: once cut, a shorted winding draws no current
   assign fault_vec[2] = excite_overcurrent_i || ovc_off_r;
   assign fault_vec[3] = batt_ovp_int_i || batt_ovp_ext_i;
   assign fault_vec[4] = batt_uv_i;
   assign fault_vec[5] = field_on_det_i && batt_above_sp_i;
   assign fault_any    = |fault_vec;

   afl_qual_timer u_alarm (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (fault_any),
      .limit_i (ALARM_T_CYC),
      .done_o  (alarm_done)
   );

   // Lamp drops in the cycle after all faults clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lamp_o <= 1'b0;
      end else begin
         lamp_o <= alarm_done && fault_any;
      end
   end

   sequence s_trip;
      !ovc_off_r && excite_overcurrent_i;
   endsequence

   sequence s_off_then_dark;
      ovc_off_r ##1 !field_o;
   endsequence

   preex_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_r == MD_PREEX && !ovc_off_r |-> pwm_duty == 10'h07d)
      else $error("Pre-excitation duty wrong");

   self_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_r == MD_SELF && !ovc_off_r |-> pwm_duty == 10'h03c)
      else $error("Self-start duty wrong");

   fixed_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_r == MD_FIXED && !ovc_off_r |-> pwm_duty == 10'h028)
      else $error("Fixed excitation duty wrong");

   start_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(mode_r) == MD_DELAY && mode_r == MD_REG |-> $past(delay_done))
      else $error("Regulation began before the start delay");

   ovc_trip_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_trip |=> s_off_then_dark)
      else $error("Field not cut on over-current");

   retry_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(ovc_off_r) |-> $past(retry_done))
      else $error("Field retried before the retry time");

   ramp_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ramp_r) |-> $past(rotor_speed_input_i) < 12'h140)
      else $error("Ramp engaged above the frequency limit");

   ramp_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ramp_r) |-> ({1'b0, $past(dem_eff)} > {1'b0, $past(cur_r)} + 11'h043)
                        && cur_r == $past(cur_r) + 10'h035)
      else $error("Ramp entry or blind-zone step wrong");

   rise_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ramp_r && $past(ramp_r) && cur_r == $past(cur_r) + 10'h001
      |-> $past(tick_r) >= UP_STEP - 1)
      else $error("Ramp rose too fast");

   fall_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(ramp_r) && cur_r == $past(cur_r) - 10'h001 && mode_r == MD_REG
      && $past(mode_r) == MD_REG |-> $past(tick_r) >= DN_STEP - 1)
      else $error("Ramp fell too fast");

   lamp_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(lamp_o) |-> $past(alarm_done) && $past(fault_any))
      else $error("Lamp lit before the qualify time");

   lamp_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !fault_any |=> !lamp_o)
      else $error("Lamp stayed on without a fault");

endmodule

// ---- tb/afl_field_load.sv ----
`timescale 1ns/10ps
// Field winding seen from the driver: shorts on command, pulse widths logged
module afl_field_load (
   input  wire logic        clk_i,
   input  wire logic        field_i,
   input  wire logic        short_gnd_i,
   input  wire logic        short_batt_i,
   output logic             overcurrent_o,
   output logic             on_det_o,
   output logic [31:0]      pulse_cyc_o
);
   logic [31:0] run_r  = 32'h0;
   logic [31:0] last_r = 32'h0;
   // Current flows only while driven, so a short trips again on each retry
   assign overcurrent_o = short_gnd_i & field_i;
   // A winding tied to the battery reads as on whatever the driver does
   assign on_det_o      = field_i | short_batt_i;
   assign pulse_cyc_o   = last_r;
   // Width of the last finished high pulse, in clock cycles
   always @(posedge clk_i) begin
      if (field_i === 1'b1) begin
         run_r <= run_r + 32'h1;
      end else begin
         last_r <= (run_r != 32'h0) ? run_r : last_r;
         run_r  <= 32'h0;
      end
   end
endmodule

// ---- tb/tb_alternator_field_lrc_alarm.sv ----
`timescale 1ns/10ps
// Field drive and lamp bench with shortened counts
module tb_alternator_field_lrc_alarm;
   import afl_pkg::*;
   localparam int unsigned PER = 2000;
   localparam int unsigned DLY = 200;
   localparam int unsigned RET = 50;
   localparam int unsigned ALM = 100;
   localparam int unsigned UPS = 8;
   localparam int unsigned DNS = 3;
   logic        clk_i, ack, ocur, on_det, field, lamp;
   logic        rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sh_gnd = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [6:0]  flt = 7'h00;
   logic [11:0] spd = 12'h000;
   logic [31:0] wdat = 32'h0, rdat_w, rdat, pulse, seed;
   logic [9:0]  d;
   afl_mode_t   prev;
   int          mismatches = 0, comparisons = 0, n;
   logic [3:0]  ctl [3] = '{4'h1, 4'h2, 4'h4};
   afl_mode_t   emd [3] = '{MD_SELF, MD_FIXED, MD_DELAY};
   logic [9:0]  edu [3] = '{SELF_START_DUTY, FIXED_EXCITE_DUTY, PRE_EXCITE_DUTY};
   int          fbit [7] = '{8, 9, 11, 11, 12, 13, 8};

   // Faults: missing, floor, ovp int, ovp ext, uv, short to battery, slow rotor
   afl_field_ctrl #(.PWM_PERIOD(PER), .DELAY_CYC(DLY), .RETRY_T_CYC(RET),
      .ALARM_T_CYC(ALM), .UP_STEP(UPS), .DN_STEP(DNS)) afl_field_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_w), .wb_ack_o(ack),
      .rotor_speed_input_i(flt[6] ? 12'h032 : spd), .rotor_missing_i(flt[0]),
      .rotor_floor_low_i(flt[1]), .excite_overcurrent_i(ocur), .batt_above_sp_i(flt[5]),
      .field_on_det_i(on_det), .batt_ovp_int_i(flt[2]), .batt_ovp_ext_i(flt[3]),
      .batt_uv_i(flt[4]), .field_o(field), .lamp_o(lamp));
   afl_field_load afl_field_load_inst (.clk_i(clk_i), .field_i(field), .short_gnd_i(sh_gnd),
      .short_batt_i(flt[5]), .overcurrent_o(ocur), .on_det_o(on_det), .pulse_cyc_o(pulse));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // High time of one field period for a duty in tenths of a percent
   function automatic logic [31:0] width(input logic [9:0] dt);
      return 32'(dt) * PER / 1000;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Ramp readings depend on where the bus cycle lands, so allow a small band
   task automatic near(input logic [31:0] seen, input logic [31:0] exp, input int tol);
      check((seen + tol >= exp && seen <= exp + tol) ? exp : seen, exp);
   endtask
   // Classic cycle: everything held until ack is seen at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] v);
      int k = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, v};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 40);
      rdat = rdat_w;
      check({31'h0, ack}, 32'h1);
      {cyc, stb} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, 4'hf, v);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 4'hf, 32'h0);
   endtask
   task automatic mode_is(input afl_mode_t m);
      rd(REG_STATUS);
      check({29'h0, rdat[2:0]}, {29'h0, m});
   endtask
   // Cycles until the field drive reaches level v, bounded by lim
   task automatic await(input logic v, input int lim);
      n = 0;
      while (field !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      seed = 32'hcbcc6b80;
      prev = MD_PREEX;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({30'h0, field, lamp}, 32'h0);
      // Reset values, a dead byte lane and an unmapped address
      rd(REG_CTRL);
      check(rdat, {28'h0, CTRL_RESET});
      bus(1'b1, REG_CTRL, 4'h0, 32'h0);
      rd(REG_CTRL);
      check(rdat, {28'h0, CTRL_RESET});
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10);
      check(rdat, 32'h0);
      // The first pulse after reset is one cycle short, so judge the second
      repeat (2 * PER + 100) @(posedge clk_i);
      check(pulse, width(PRE_EXCITE_DUTY));
      // Each fixed-duty mode, entered from pre-excitation across the hysteresis
      for (int i = 0; i < 3; i++) begin
         spd <= 12'h06e;
         repeat (4) @(posedge clk_i);
         mode_is(prev);
         spd <= 12'h032;
         repeat (4) @(posedge clk_i);
         wr(REG_CTRL, {28'h0, ctl[i]});
         spd <= 12'h0c8;
         repeat (4) @(posedge clk_i);
         mode_is(emd[i]);
         rd(REG_DUTY);
         check(rdat, {22'h0, edu[i]});
         if (i < 2) begin
            repeat (2 * PER + 100) @(posedge clk_i);
            check(pulse, width(edu[i]));
         end
         prev = emd[i];
      end
      repeat (DLY - 40) @(posedge clk_i);
      mode_is(MD_DELAY);
      repeat (60) @(posedge clk_i);
      mode_is(MD_REG);
      // Random demands with the ramp off, then clamp and byte lanes
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         d = 10'(32'h00a + seed % 32'h3d4);
         wr(REG_DEMAND, {22'h0, d});
         rd(REG_DUTY);
         check(rdat, {22'h0, d});
         repeat (2 * PER + 100) @(posedge clk_i);
         check(pulse, width(d));
      end
      wr(REG_DEMAND, 32'h3ff);
      rd(REG_DUTY);
      check(rdat, {22'h0, DUTY_MAX});
      bus(1'b1, REG_DEMAND, 4'h1, 32'h155);
      rd(REG_DEMAND);
      check(rdat, 32'h355);
      // Ramp limiter: exact trigger delta, engage step, both slopes, speed limit
      spd <= 12'h032;
      repeat (4) @(posedge clk_i);
      wr(REG_CTRL, 32'h8);
      wr(REG_DEMAND, 32'h64);
      spd <= 12'h0c8;
      repeat (400) @(posedge clk_i);
      d = 10'h064 + RAMP_TRIGGER_DELTA;
      wr(REG_DEMAND, {22'h0, d});
      rd(REG_DUTY);
      check(rdat, {22'h0, d});
      wr(REG_DEMAND, 32'h1f4);
      rd(REG_DUTY);
      near(rdat, {22'h0, d + RAMP_START_STEP}, 1);
      rd(REG_STATUS);
      check({31'h0, rdat[3]}, 32'h1);
      repeat (100 * UPS) @(posedge clk_i);
      rd(REG_DUTY);
      near(rdat, {22'h0, d + RAMP_START_STEP} + 32'h64, 3);
      wr(REG_DEMAND, 32'hc8);
      repeat (20 * DNS) @(posedge clk_i);
      rd(REG_DUTY);
      near(rdat, {22'h0, d + RAMP_START_STEP} + 32'h50, 4);
      repeat (400) @(posedge clk_i);
      rd(REG_DUTY);
      check(rdat, 32'hc8);
      spd <= RAMP_LIMIT_HZ;
      repeat (4) @(posedge clk_i);
      wr(REG_DEMAND, 32'h258);
      rd(REG_DUTY);
      check(rdat, 32'h258);
      // Shorted winding from a period start: trip, hold off, retry, trip again
      await(1'b0, 2 * PER);
      sh_gnd <= 1'b1;
      await(1'b1, 2 * PER);
      await(1'b0, 10);
      near(n, 2, 1);
      await(1'b1, 2 * PER);
      near(n, RET + 4, 4);
      await(1'b0, 10);
      rd(REG_STATUS);
      check({31'h0, rdat[4]}, 32'h1);
      check({31'h0, rdat[10]}, 32'h1);
      sh_gnd <= 1'b0;
      repeat (2 * PER + 100) @(posedge clk_i);
      check(pulse, width(10'h258));
      // Each fault, first with a one-gap restart, then held to qualify
      for (int i = 0; i < 7; i++) begin
         flt[i] <= 1'b1;
         repeat (ALM - 40) @(posedge clk_i);
         flt[i] <= 1'b0;
         repeat (2) @(posedge clk_i);
         flt[i] <= 1'b1;
         repeat (ALM - 40) @(posedge clk_i);
         check({31'h0, lamp}, 32'h0);
         repeat (50) @(posedge clk_i);
         check({31'h0, lamp}, 32'h1);
         rd(REG_STATUS);
         check({31'h0, rdat[fbit[i]]}, 32'h1);
         flt[i] <= 1'b0;
         repeat (4) @(posedge clk_i);
         check({31'h0, lamp}, 32'h0);
      end
      complete_run();
   end

   // Whole sequence needs about 40000 cycles; a hang ends here
   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      complete_run();
   end
endmodule
